/* tcc_pkg.sv */
// Behaviour
// - Source 000/001 ext rise/fall; 100/101/110/111 fxx/1024, /64, /16, /1.
// - The count register is eight bits, read-only, and resets to zero.
// - The count advances by one on every event of the selected clock source.
// - A match after an advance sets the request flag and raises a request.
// - After a match the count returns to zero and keeps counting on its own.
// - The reference register is eight bits, write-only, reset to all ones.
// - Matches recur every reference plus one periods of the count clock.
// - Every match inverts the output latch.
// - Restart while enabled clears latch, count and flag; counting resumes.
// - The restart bit clears itself once counting resumes.
// - While disabled the output latch keeps its state and stays readable.
// - Enable low stops counting and keeps the count; enable high counts.
// - Bit-wide output enable gates the latch onto the pin; resets to zero.
// - The latch always feeds the serial clock selector, whatever the enable.
// - Mode bits 7, 1 and 0 read as zero; reset clears the mode register.
package tcc_pkg;

  // ----------------------------------------------------------------
  // Register map (nibble addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] MODE_LO_ADDR = 12'h0f90;
  localparam logic [11:0] MODE_HI_ADDR = 12'h0f91;
  localparam logic [11:0] OUT_EN_ADDR = 12'h0f92;
  localparam logic [11:0] LATCH_ADDR = 12'h0f93;
  localparam logic [11:0] COUNT_LO_ADDR = 12'h0f94;
  localparam logic [11:0] COUNT_HI_ADDR = 12'h0f95;
  localparam logic [11:0] REF_LO_ADDR = 12'h0f96;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RESTART_POS = 3;
  localparam int ENABLE_POS = 2;
  localparam int OUT_EN_POS = 2;
  localparam int NEIGH_EN_POS = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] REF_RESET = 8'hff;

  // ----------------------------------------------------------------
  // Prescaler taps (all ones in the low bits marks one period)
  // ----------------------------------------------------------------
  localparam int PSC_W = 10;
  localparam logic [9:0] DIV1024_MASK = 10'h03ff;
  localparam logic [9:0] DIV64_MASK = 10'h003f;
  localparam logic [9:0] DIV16_MASK = 10'h000f;

  typedef enum logic [2:0] {
    SRC_EXT_RISE = 3'b000,
    SRC_EXT_FALL = 3'b001,
    SRC_DIV1024 = 3'b100,
    SRC_DIV64 = 3'b101,
    SRC_DIV16 = 3'b110,
    SRC_DIV1 = 3'b111
  } tcc_src_e;

  typedef struct packed {
    logic restart;
    logic enable;
    logic [2:0] src;
  } tcc_mode_s;

endpackage : tcc_pkg

/* tcc_edge_sync.sv */
`timescale 1ns/1ps
module tcc_edge_sync (
  input wire logic clk,       // System clock
  input wire logic sys_rst,   // Async reset, active high
  input wire logic din,       // Raw external input
  input wire logic fall_sel,  // 1 selects falling edges
  output logic pulse          // One-cycle edge pulse
);

  logic sync1;
  logic sync2;
  logic prev;

  // ----------------------------------------------------------------
  // Synchroniser and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync1 <= din;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse <= 1'b0;
    end else if (fall_sel) begin
      pulse <= prev & ~sync2;
    end else begin
      pulse <= sync2 & ~prev;
    end
  end

  single_pulse_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    pulse |=> !pulse) else $error("edge pulse longer than one cycle");

endmodule : tcc_edge_sync

/* tcc_timer.sv */
`timescale 1ns/1ps
module tcc_timer (
  input wire logic clk,                     // System clock, fxx
  input wire logic sys_rst,                 // Async reset, active high
  input wire logic [11:0] mem_addr,         // Nibble address
  input wire logic [7:0] mem_wdata,         // Write data
  input wire logic mem_wr,                  // 8-bit write, even address
  input wire logic mem_bit_wr,              // 1-bit write
  input wire logic [1:0] mem_bit_pos,       // Bit index of 1-bit write
  input wire logic mem_bit_val,             // Value of 1-bit write
  input wire logic mem_rd,                  // Read strobe
  output logic [7:0] mem_rdata,             // Read data, next cycle
  input wire logic irq_flag_clear,          // Request flag clear
  input wire logic external_count_input,    // External count clock
  output logic timer_irq_flag,              // Sticky request flag
  output logic timer_irq_pulse,             // One-cycle request
  output logic timer_clock_output_pin,      // Gated latch to pin
  output logic toggle_output_latch,         // Latch to serial clock sel
  output logic clock_pin_output_enable,     // Output enable flag
  output logic neighbour_output_enable      // Neighbour enable flag
);

  tcc_pkg::tcc_mode_s mode;
  logic [7:0] timer_count_value;
  logic [7:0] timer_compare_reference;
  logic [tcc_pkg::PSC_W-1:0] psc;
  logic ext_pulse;
  logic tick;
  logic do_restart;
  logic cnt_step;
  logic match;
  logic [7:0] next_count;

  // ----------------------------------------------------------------
  // External input
  // ----------------------------------------------------------------
  tcc_edge_sync u_edge (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(external_count_input),
    .fall_sel(mode.src[0]),
    .pulse(ext_pulse)
  );

  // ----------------------------------------------------------------
  // Prescaler and source select
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      psc <= '0;
    end else begin
      psc <= psc + 10'h001;
    end
  end

  always_comb begin
    case (mode.src)
      tcc_pkg::SRC_EXT_RISE: tick = ext_pulse;
      tcc_pkg::SRC_EXT_FALL: tick = ext_pulse;
      tcc_pkg::SRC_DIV1024: begin
        tick = (psc & tcc_pkg::DIV1024_MASK) == tcc_pkg::DIV1024_MASK;
      end
      tcc_pkg::SRC_DIV64: begin
        tick = (psc & tcc_pkg::DIV64_MASK) == tcc_pkg::DIV64_MASK;
      end
      tcc_pkg::SRC_DIV16: begin
        tick = (psc & tcc_pkg::DIV16_MASK) == tcc_pkg::DIV16_MASK;
      end
      tcc_pkg::SRC_DIV1: tick = 1'b1;
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Count and compare
  // ----------------------------------------------------------------
  assign do_restart = mode.restart & mode.enable;
  assign cnt_step = mode.enable & ~do_restart & tick;

  always_comb begin
    if (timer_count_value == timer_compare_reference) begin
      next_count = 8'h00;
    end else begin
      next_count = timer_count_value + 8'h01;
    end
  end

  assign match = cnt_step & (next_count == timer_compare_reference);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_count_value <= tcc_pkg::COUNT_RESET;
    end else if (do_restart) begin
      timer_count_value <= tcc_pkg::COUNT_RESET;
    end else if (cnt_step) begin
      timer_count_value <= next_count;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      toggle_output_latch <= 1'b0;
    end else if (do_restart) begin
      toggle_output_latch <= 1'b0;
    end else if (match) begin
      toggle_output_latch <= ~toggle_output_latch;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_irq_flag <= 1'b0;
      timer_irq_pulse <= 1'b0;
    end else begin
      timer_irq_pulse <= match;
      if (match) begin
        timer_irq_flag <= 1'b1;
      end else if (do_restart || irq_flag_clear) begin
        timer_irq_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_clock_output_pin <= 1'b0;
    end else begin
      timer_clock_output_pin <= clock_pin_output_enable
        & toggle_output_latch;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= '0;
    end else if (mem_wr && mem_addr == tcc_pkg::MODE_LO_ADDR) begin
      mode.restart <= mem_wdata[tcc_pkg::RESTART_POS];
      mode.enable <= mem_wdata[tcc_pkg::ENABLE_POS];
      mode.src <= mem_wdata[6:4];
    end else if (mem_bit_wr && mem_addr == tcc_pkg::MODE_LO_ADDR
                 && mem_bit_pos == 2'(tcc_pkg::RESTART_POS)) begin
      mode.restart <= mem_bit_val;
    end else if (do_restart) begin
      mode.restart <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_compare_reference <= tcc_pkg::REF_RESET;
    end else if (mem_wr && mem_addr == tcc_pkg::REF_LO_ADDR) begin
      timer_compare_reference <= mem_wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_pin_output_enable <= 1'b0;
      neighbour_output_enable <= 1'b0;
    end else if (mem_bit_wr && mem_addr == tcc_pkg::OUT_EN_ADDR) begin
      if (mem_bit_pos == 2'(tcc_pkg::OUT_EN_POS)) begin
        clock_pin_output_enable <= mem_bit_val;
      end else if (mem_bit_pos == 2'(tcc_pkg::NEIGH_EN_POS)) begin
        neighbour_output_enable <= mem_bit_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  function automatic logic [3:0] nib(input logic [11:0] a);
    logic [3:0] r;
    r = 4'h0;
    if (a == tcc_pkg::MODE_LO_ADDR) begin
      r = {mode.restart, mode.enable, 2'b00};
    end else if (a == tcc_pkg::MODE_HI_ADDR) begin
      r = {1'b0, mode.src};
    end else if (a == tcc_pkg::OUT_EN_ADDR) begin
      r = {1'b0, clock_pin_output_enable, neighbour_output_enable, 1'b0};
    end else if (a == tcc_pkg::LATCH_ADDR) begin
      r = {3'b000, toggle_output_latch};
    end else if (a == tcc_pkg::COUNT_LO_ADDR) begin
      r = timer_count_value[3:0];
    end else if (a == tcc_pkg::COUNT_HI_ADDR) begin
      r = timer_count_value[7:4];
    end
    return r;
  endfunction : nib

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_rdata <= 8'h00;
    end else if (mem_rd) begin
      mem_rdata <= {nib(mem_addr + 12'h001), nib(mem_addr)};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  slow_source_tick_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mode.src == tcc_pkg::SRC_DIV1024 && tick) |-> psc == 10'h3ff)
    else $error("fxx/1024 tick off its period");
  count_step_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (cnt_step && timer_count_value != timer_compare_reference)
    |=> timer_count_value == $past(timer_count_value) + 8'h01)
    else $error("count did not advance by one");
  match_flag_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    match |=> (timer_irq_flag && timer_irq_pulse)
    ##1 (timer_irq_pulse == $past(match)))
    else $error("match did not raise request");
  match_wrap_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (cnt_step && timer_count_value == timer_compare_reference)
    |=> timer_count_value == 8'h00)
    else $error("count did not wrap to zero");
  latch_toggle_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (match && !do_restart)
    |=> toggle_output_latch != $past(toggle_output_latch))
    else $error("latch did not toggle on match");
  restart_clear_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (do_restart && !mem_wr && !mem_bit_wr) |=> (timer_count_value == 8'h00
    && !toggle_output_latch && !timer_irq_flag && !mode.restart))
    else $error("restart did not clear state");
  disabled_hold_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !mode.enable |=> $stable(timer_count_value)
    && $stable(toggle_output_latch))
    else $error("state moved while disabled");
  pin_gate_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    1'b1 |=> timer_clock_output_pin
    == ($past(clock_pin_output_enable) & $past(toggle_output_latch)))
    else $error("clock pin not gated by enable");

endmodule : tcc_timer

/* tcc_ext_src.sv */
`timescale 1ns/1ps
module tcc_ext_src (
  input wire logic clk,          // System clock
  input wire logic go,           // Start a burst
  input wire logic [7:0] edges,  // Pulses in the burst
  input wire logic [3:0] half,   // Half period in clocks
  output logic ext_clk,          // Count clock to the pin
  output logic busy              // Burst running
);
  int n;
  // ----------------------------------------------------------------
  // Burst generator, line stands low between bursts
  // ----------------------------------------------------------------
  initial begin
    ext_clk = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      n = edges;
      repeat (n) begin
        repeat (half) @(negedge clk);
        ext_clk = 1'b1;
        repeat (half) @(negedge clk);
        ext_clk = 1'b0;
      end
      busy = 1'b0;
    end
  end
endmodule : tcc_ext_src

/* tb.sv */
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [2:0] src;
    logic [7:0] ref_v;
    logic [15:0] div;
  } tcc_row_s;
  localparam tcc_row_s ROWS [4] = '{
    '{3'b111, 8'h03, 16'h0001}, '{3'b110, 8'h02, 16'h0010},
    '{3'b101, 8'h01, 16'h0040}, '{3'b100, 8'h01, 16'h0400}};
  logic clk = 1'b0, sys_rst = 1'b1, mem_wr = 1'b0, mem_bit_wr = 1'b0;
  logic mem_bit_val = 1'b0, mem_rd = 1'b0, irq_flag_clear = 1'b0;
  logic [11:0] mem_addr = 12'h0000;
  logic [7:0] mem_wdata = 8'h00, mem_rdata, edges = 8'h00, rd;
  logic [1:0] mem_bit_pos = 2'b00;
  logic [3:0] half = 4'h1;
  logic go = 1'b0, ext_clk, busy, flag, pulse, pin, latch, oe, neigh;
  int fail_count = 0, num_checks = 0, cyc;
  tcc_timer dut (.clk(clk), .sys_rst(sys_rst), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_bit_wr(mem_bit_wr),
    .mem_bit_pos(mem_bit_pos), .mem_bit_val(mem_bit_val),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .irq_flag_clear(irq_flag_clear), .external_count_input(ext_clk),
    .timer_irq_flag(flag), .timer_irq_pulse(pulse),
    .timer_clock_output_pin(pin), .toggle_output_latch(latch),
    .clock_pin_output_enable(oe), .neighbour_output_enable(neigh));
  tcc_ext_src ext (.clk(clk), .go(go), .edges(edges), .half(half),
    .ext_clk(ext_clk), .busy(busy));
  initial begin
    forever #4 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic wr8(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(negedge clk);
    mem_wr = 1'b0;
  endtask : wr8
  task automatic bitwr(input logic [11:0] a, input logic [1:0] p,
    input logic v);
    @(negedge clk);
    mem_addr = a;
    mem_bit_pos = p;
    mem_bit_val = v;
    mem_bit_wr = 1'b1;
    @(negedge clk);
    mem_bit_wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask : bitwr
  task automatic rd8(input logic [11:0] a);
    @(negedge clk);
    mem_addr = a;
    mem_rd = 1'b1;
    @(negedge clk);
    mem_rd = 1'b0;
    @(negedge clk);
    rd = mem_rdata;
  endtask : rd8
  task automatic wait_pulse;
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (pulse !== 1'b1 && cyc < 5000);
    if (cyc >= 5000) fail_count++;
  endtask : wait_pulse
  task automatic burst(input logic [7:0] n, input logic [3:0] h);
    @(negedge clk);
    edges = n;
    half = h;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (int i = 0; i < 4000 && busy === 1'b1; i++) @(negedge clk);
    repeat (8) @(negedge clk);
  endtask : burst
  task automatic rst_checks;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    check({flag, pulse, pin, latch, oe, neigh}, 16'h0000);
    rd8(tcc_pkg::COUNT_LO_ADDR);
    check(rd, tcc_pkg::COUNT_RESET);
    rd8(tcc_pkg::MODE_LO_ADDR);
    check(rd, 8'h00);
    rd8(tcc_pkg::OUT_EN_ADDR);
    check(rd[3:0], 4'h0);
    rd8(tcc_pkg::REF_LO_ADDR);
    check(rd, 8'h00);
  endtask : rst_checks
  initial begin
    #800000;
    fail_count++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_checks();
    foreach (ROWS[i]) begin
      wr8(tcc_pkg::REF_LO_ADDR, ROWS[i].ref_v);
      wr8(tcc_pkg::MODE_LO_ADDR, {1'b0, ROWS[i].src, 4'b1100});
      wait_pulse();
      check({flag, latch, pin}, 16'h0006);
      wait_pulse();
      check(cyc, (ROWS[i].ref_v + 16'h1) * ROWS[i].div);
      check(latch, 1'b0);
    end
    wr8(tcc_pkg::REF_LO_ADDR, 8'h03);
    wr8(tcc_pkg::MODE_LO_ADDR, 8'h0c);
    rd8(tcc_pkg::MODE_LO_ADDR);
    check(rd, 8'h04);
    burst(8'h03, 4'h1);
    rd8(tcc_pkg::COUNT_LO_ADDR);
    check(rd, 8'h03);
    check({flag, latch}, 16'h0003);
    bitwr(tcc_pkg::OUT_EN_ADDR, 2'(tcc_pkg::OUT_EN_POS), 1'b1);
    check({oe, pin}, 16'h0003);
    rd8(tcc_pkg::OUT_EN_ADDR);
    check(rd[3:0], 4'h4);
    bitwr(tcc_pkg::OUT_EN_ADDR, 2'(tcc_pkg::OUT_EN_POS), 1'b0);
    check({oe, pin, latch}, 16'h0001);
    bitwr(tcc_pkg::OUT_EN_ADDR, 2'(tcc_pkg::NEIGH_EN_POS), 1'b1);
    check({neigh, oe}, 16'h0002);
    @(negedge clk);
    irq_flag_clear = 1'b1;
    @(negedge clk);
    irq_flag_clear = 1'b0;
    check(flag, 1'b0);
    burst(8'h01, 4'h5);
    rd8(tcc_pkg::COUNT_LO_ADDR);
    check(rd, 8'h00);
    wr8(tcc_pkg::MODE_LO_ADDR, 8'h14);
    burst(8'h02, 4'h3);
    rd8(tcc_pkg::COUNT_LO_ADDR);
    check(rd, 8'h02);
    wr8(tcc_pkg::MODE_LO_ADDR, 8'hf3);
    repeat (50) @(negedge clk);
    rd8(tcc_pkg::COUNT_LO_ADDR);
    check(rd, 8'h02);
    rd8(tcc_pkg::MODE_LO_ADDR);
    check(rd, 8'h70);
    rd8(tcc_pkg::LATCH_ADDR);
    check(rd[0], 1'b1);
    bitwr(tcc_pkg::MODE_LO_ADDR, 2'(tcc_pkg::RESTART_POS), 1'b1);
    rd8(tcc_pkg::LATCH_ADDR);
    check(rd, 8'h21);
    wr8(tcc_pkg::MODE_LO_ADDR, 8'h0c);
    repeat (3) @(negedge clk);
    check({flag, latch}, 16'h0000);
    rd8(tcc_pkg::COUNT_LO_ADDR);
    check(rd, 8'h00);
    rd8(tcc_pkg::MODE_LO_ADDR);
    check(rd, 8'h04);
    burst(8'h02, 4'h1);
    rd8(tcc_pkg::COUNT_LO_ADDR);
    check(rd, 8'h02);
    bitwr(tcc_pkg::MODE_LO_ADDR, 2'(tcc_pkg::RESTART_POS), 1'b1);
    rd8(tcc_pkg::COUNT_LO_ADDR);
    check(rd, 8'h00);
    rd8(tcc_pkg::MODE_LO_ADDR);
    check(rd, 8'h04);
    wr8(tcc_pkg::MODE_LO_ADDR, 8'h24);
    repeat (40) @(negedge clk);
    rd8(tcc_pkg::COUNT_LO_ADDR);
    check(rd, 8'h00);
    wr8(tcc_pkg::MODE_LO_ADDR, 8'h7c);
    repeat (10) @(negedge clk);
    sys_rst = 1'b1;
    rst_checks();
    wr8(tcc_pkg::MODE_LO_ADDR, 8'h7c);
    wait_pulse();
    wait_pulse();
    check(cyc, 16'h0100);
    conclude();
  end
endmodule : tb
